// [rtl/dpwm_button.v]
/*
 Pushbutton step generator for one channel: debounce, delay, repeat.
 Assumes a three-state level already classified by the top.
*/
`timescale 1ns/1ns
`include "dpwm_regs.vh"
module dpwm_button #(
    parameter DEB_CYC = `DPWM_DEB_CYC,
    parameter DLY_CYC = `DPWM_DLY_CYC,
    parameter REP_CYC = `DPWM_REP_CYC
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire resetn_in,
    // Level and enable
    input wire [1:0] level_in,
    input wire enable_in,
    // Step request
    output reg up_out,
    output reg down_out
);
    reg [1:0] last_q;
    reg [24:0] cnt_q;
    reg stable_q;
    reg held_q;
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            last_q <= `DPWM_LVL_MID;
            cnt_q <= 25'h0000000;
            stable_q <= 1'b0;
            held_q <= 1'b0;
            up_out <= 1'b0;
            down_out <= 1'b0;
        end
        else
        begin
            up_out <= 1'b0;
            down_out <= 1'b0;
            last_q <= level_in;
            if (!enable_in || level_in != last_q || level_in == `DPWM_LVL_MID)
            begin
                // Any change restarts the wait so bounce never counts
                cnt_q <= 25'h0000000;
                stable_q <= 1'b0;
                held_q <= 1'b0;
            end
            else if (!stable_q)
            begin
                if (cnt_q == DEB_CYC[24:0] - 25'h1)
                begin
                    stable_q <= 1'b1;
                    cnt_q <= 25'h0000000;
                    up_out <= (level_in == `DPWM_LVL_HIGH);
                    down_out <= (level_in == `DPWM_LVL_LOW);
                end
                else
                    cnt_q <= cnt_q + 25'h1;
            end
            else if (cnt_q == (held_q ? REP_CYC[24:0] : DLY_CYC[24:0]) - 25'h1)
            begin
                held_q <= 1'b1;
                cnt_q <= 25'h0000000;
                up_out <= (level_in == `DPWM_LVL_HIGH);
                down_out <= (level_in == `DPWM_LVL_LOW);
            end
            else
                cnt_q <= cnt_q + 25'h1;
        end
    end
endmodule

// [rtl/dpwm_pwm.v]
/*
 One PWM channel: high for code/64 of each 64-slot period.
 Assumes a shared slot counter from the top; shutdown releases the pin.
*/
`timescale 1ns/1ns
`include "dpwm_regs.vh"
module dpwm_pwm #(
    parameter CODE_W = 6
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire resetn_in,
    // Control
    input wire [CODE_W-1:0] code_in,
    input wire [CODE_W-1:0] slot_in,
    input wire sleep_in,
    // Pin
    output reg duty_out,
    output reg duty_oe_out
);
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            duty_out <= 1'b0;
            duty_oe_out <= 1'b0;
        end
        else
        begin
            duty_out <= !sleep_in && (slot_in < code_in);
            duty_oe_out <= !sleep_in;
        end
    end
endmodule

// [rtl/dpwm_regs.vh]
/*
 Timing and code constants for the dual PWM up/down control block.
 Assumes a 50 MHz system clock; counts are derived from times here.
*/
`ifndef DPWM_REGS_VH
`define DPWM_REGS_VH
`define DPWM_CLK_HZ 50000000
`define DPWM_CODE_W 6
`define DPWM_CODE_MID 6'h20
`define DPWM_CODE_MAX 6'h3F
`define DPWM_CODE_MIN 6'h00
`define DPWM_PRESCALE 8'hA0
`define DPWM_DEB_US 12800
`define DPWM_DEB_CYC ((`DPWM_CLK_HZ / 1000000) * `DPWM_DEB_US)
`define DPWM_DLY_MS 410
`define DPWM_DLY_CYC ((`DPWM_CLK_HZ / 1000) * `DPWM_DLY_MS)
`define DPWM_REP_MHZ 19500
`define DPWM_REP_CYC ((`DPWM_CLK_HZ / `DPWM_REP_MHZ) * 1000)
`define DPWM_LVL_LOW 2'h0
`define DPWM_LVL_HIGH 2'h1
`define DPWM_LVL_MID 2'h2
`endif

// [rtl/dpwm_top.v]
/*
 Dual 6-bit PWM code controller with pulse and pushbutton step modes.
 Assumes resetn_in is the supply power-up reset and that the pad logic
 reports a floating step pin on the *_float_in inputs while bias is on.
*/
`timescale 1ns/1ns
`include "dpwm_regs.vh"
module dpwm_top #(
    parameter CODE_W = `DPWM_CODE_W,
    parameter DEB_CYC = `DPWM_DEB_CYC,
    parameter DLY_CYC = `DPWM_DLY_CYC,
    parameter REP_CYC = `DPWM_REP_CYC
) (
    // Clock and power-up reset
    input wire clk_sys_in,
    input wire resetn_in,
    // Step inputs with pad float sense
    input wire ch1_step_input_in,
    input wire ch2_step_input_in,
    input wire ch1_step_float_in,
    input wire ch2_step_float_in,
    // Shutdown
    input wire sleep_request_n_in,
    // PWM pins
    output wire ch1_duty_out,
    output wire ch1_duty_oe_out,
    output wire ch2_duty_out,
    output wire ch2_duty_oe_out,
    // Pad bias control, mode status and channel codes
    output reg bias_enable_out,
    output reg button_mode_out,
    output reg [CODE_W-1:0] ch1_code_out,
    output reg [CODE_W-1:0] ch2_code_out
);
    localparam ST_DETECT = 1'b0;
    localparam ST_RUN = 1'b1;

    reg state_q;
    reg [1:0] step_q;
    reg [7:0] pre_q;
    reg [CODE_W-1:0] slot_q;
    wire [1:0] lvl1;
    wire [1:0] lvl2;
    wire up1;
    wire dn1;
    wire up2;
    wire dn2;
    wire sleep;

    // Three-state classification of a step pin
    function [1:0] classify;
        input level;
        input floating;
        begin
            if (floating)
                classify = `DPWM_LVL_MID;
            else if (level)
                classify = `DPWM_LVL_HIGH;
            else
                classify = `DPWM_LVL_LOW;
        end
    endfunction

    // Next code for one channel given the step requests
    function [CODE_W-1:0] next_code;
        input [CODE_W-1:0] code;
        input button;
        input pulse_edge;
        input up;
        input down;
        begin
            next_code = code;
            if (!button && pulse_edge)
                next_code = code + 1'b1;
            else if (button && up && code != `DPWM_CODE_MAX)
                next_code = code + 1'b1;
            else if (button && down && code != `DPWM_CODE_MIN)
                next_code = code - 1'b1;
        end
    endfunction

    assign sleep = !sleep_request_n_in;
    assign lvl1 = classify(ch1_step_input_in, ch1_step_float_in);
    assign lvl2 = classify(ch2_step_input_in, ch2_step_float_in);

    // Mode is caught once, on the first clock after reset release
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= ST_DETECT;
            button_mode_out <= 1'b0;
            bias_enable_out <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_DETECT:
                begin
                    state_q <= ST_RUN;
                    button_mode_out <= ch1_step_float_in && ch2_step_float_in;
                    bias_enable_out <= ch1_step_float_in && ch2_step_float_in;
                end
                ST_RUN:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    // Step edge history for pulse mode
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            step_q <= 2'h0;
        else
            step_q <= {ch2_step_input_in, ch1_step_input_in};
    end

    // Codes: midscale at power-up only; shutdown leaves them alone
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ch1_code_out <= `DPWM_CODE_MID;
            ch2_code_out <= `DPWM_CODE_MID;
        end
        else if (state_q == ST_RUN && !sleep)
        begin
            ch1_code_out <= next_code(ch1_code_out, button_mode_out,
                ch1_step_input_in && !step_q[0], up1, dn1);
            ch2_code_out <= next_code(ch2_code_out, button_mode_out,
                ch2_step_input_in && !step_q[1], up2, dn2);
        end
    end

    // 64 slots of 160 clocks: 3.2 us slot, 204.8 us period, about 4.9 kHz
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pre_q <= 8'h00;
            slot_q <= {CODE_W{1'b0}};
        end
        else if (sleep)
        begin
            // Stopped counters stand in for the micropower state
            pre_q <= 8'h00;
            slot_q <= {CODE_W{1'b0}};
        end
        else if (pre_q == `DPWM_PRESCALE - 8'h01)
        begin
            pre_q <= 8'h00;
            slot_q <= slot_q + 1'b1;
        end
        else
            pre_q <= pre_q + 8'h01;
    end

    dpwm_button #(
        .DEB_CYC(DEB_CYC),
        .DLY_CYC(DLY_CYC),
        .REP_CYC(REP_CYC)
    ) u_btn1 (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .level_in(lvl1),
        .enable_in(button_mode_out && state_q == ST_RUN && !sleep),
        .up_out(up1),
        .down_out(dn1)
    );

    dpwm_button #(
        .DEB_CYC(DEB_CYC),
        .DLY_CYC(DLY_CYC),
        .REP_CYC(REP_CYC)
    ) u_btn2 (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .level_in(lvl2),
        .enable_in(button_mode_out && state_q == ST_RUN && !sleep),
        .up_out(up2),
        .down_out(dn2)
    );

    dpwm_pwm #(
        .CODE_W(CODE_W)
    ) u_ch1_duty_out (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .code_in(ch1_code_out),
        .slot_in(slot_q),
        .sleep_in(sleep),
        .duty_out(ch1_duty_out),
        .duty_oe_out(ch1_duty_oe_out)
    );

    dpwm_pwm #(
        .CODE_W(CODE_W)
    ) u_ch2_duty_out (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .code_in(ch2_code_out),
        .slot_in(slot_q),
        .sleep_in(sleep),
        .duty_out(ch2_duty_out),
        .duty_oe_out(ch2_duty_oe_out)
    );
endmodule

// [tb/dpwm_checker.sv]
/* Port assertions for dpwm_top.
   Assumes a bind into dpwm_top with six-bit codes. */
`timescale 1ns/1ns
module dpwm_checker (
    // Clock and reset
    input wire clk_sys_in,
    input wire resetn_in,
    // Inputs
    input wire ch1_step_input_in,
    input wire sleep_request_n_in,
    // Outputs
    input wire ch1_duty_out,
    input wire ch1_duty_oe_out,
    input wire ch2_duty_oe_out,
    input wire bias_enable_out,
    input wire button_mode_out,
    input wire [5:0] ch1_code_out,
    input wire [5:0] ch2_code_out
);
    // Edges since release; steps count only once detect has settled
    reg [1:0] up_q;
    wire live = up_q == 2'h3 && !button_mode_out && sleep_request_n_in;
    always @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    mid_preset_a: assert property ($rose(resetn_in) |->
        ch1_code_out == 6'h20 && ch2_code_out == 6'h20) else $error("no midscale");
    mode_fixed_a: assert property (up_q[1] |->
        $stable(button_mode_out) && bias_enable_out == button_mode_out) else $error("mode");
    sleep_hiz_a: assert property (!sleep_request_n_in |=>
        !ch1_duty_oe_out && !ch2_duty_oe_out) else $error("driven in sleep");
    sleep_hold_a: assert property (!sleep_request_n_in |=>
        $stable(ch1_code_out) && $stable(ch2_code_out)) else $error("code moved");
    pulse_step_a: assert property (live && $rose(ch1_step_input_in) |=>
        ch1_code_out == $past(ch1_code_out) + 6'h01) else $error("pulse step");
    pulse_quiet_a: assert property (live && !$rose(ch1_step_input_in) |=>
        $stable(ch1_code_out)) else $error("extra count");
    button_top_a: assert property (button_mode_out && ch1_code_out == 6'h3F |=>
        ch1_code_out != 6'h00) else $error("top wrap");
    button_floor_a: assert property (button_mode_out && ch1_code_out == 6'h00 |=>
        ch1_code_out != 6'h3F) else $error("floor wrap");
    zero_low_a: assert property (ch1_code_out == 6'h00 && $past(ch1_code_out) == 6'h00 &&
        $past(ch1_code_out, 2) == 6'h00 |-> !ch1_duty_out) else $error("zero duty");
endmodule

// [tb/dpwm_host.sv]
/* Host model for both step pins: pulses, button levels, floating.
   Assumes the bench calls its tasks; pins change at falling edges. */
`timescale 1ns/1ns
module dpwm_host (
    // Clock
    input wire clk_sys_in,
    // Pins and float sense
    output reg ch1_step_out = 1'b0,
    output reg ch2_step_out = 1'b0,
    output reg ch1_float_out = 1'b0,
    output reg ch2_float_out = 1'b0
);
    // 0 low, 1 high, 2 floating
    reg [1:0] drv [1:2] = '{2'h0, 2'h0};
    // A floating pin toggles so a stale level never looks driven
    always @(negedge clk_sys_in)
    begin
        ch1_float_out <= drv[1][1];
        ch2_float_out <= drv[2][1];
        ch1_step_out <= drv[1][1] ? !ch1_step_out : drv[1][0];
        ch2_step_out <= drv[2][1] ? !ch2_step_out : drv[2][0];
    end
    task hold(input int ch, input logic [1:0] v);
        @(posedge clk_sys_in);
        drv[ch] = v;
    endtask
    task press(input int ch, input logic [1:0] v, input int n);
        hold(ch, v);
        repeat (n) @(posedge clk_sys_in);
        hold(ch, 2'h2);
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask
    task pulse(input int ch, input int n);
        repeat (n)
        begin
            hold(ch, 2'h1);
            hold(ch, 2'h1);
            hold(ch, 2'h0);
            hold(ch, 2'h0);
        end
        // Return at a falling edge so callers sample settled outputs
        @(negedge clk_sys_in);
    endtask
endmodule

// [tb/test_dpwm_top.sv]
/* Self-checking bench for dpwm_top with the host model.
   Assumes short debounce, delay and repeat counts. */
`timescale 1ns/1ns
module test_dpwm_top;
    logic clk_sys_in = 0;
    logic resetn_in = 0;
    logic sleep_request_n_in = 1;
    wire ch1_step_input_in, ch2_step_input_in, ch1_step_float_in, ch2_step_float_in;
    wire ch1_duty_out, ch1_duty_oe_out, ch2_duty_out, ch2_duty_oe_out;
    wire bias_enable_out, button_mode_out;
    wire [5:0] ch1_code_out, ch2_code_out;
    int checks = 0;
    int fail_count = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    dpwm_host host (.clk_sys_in, .ch1_step_out(ch1_step_input_in),
        .ch2_step_out(ch2_step_input_in), .ch1_float_out(ch1_step_float_in),
        .ch2_float_out(ch2_step_float_in));
    dpwm_top #(.DEB_CYC(20), .DLY_CYC(50), .REP_CYC(30)) dut (.clk_sys_in, .resetn_in,
        .ch1_step_input_in, .ch2_step_input_in, .ch1_step_float_in, .ch2_step_float_in,
        .sleep_request_n_in, .ch1_duty_out, .ch1_duty_oe_out, .ch2_duty_out,
        .ch2_duty_oe_out, .bias_enable_out, .button_mode_out, .ch1_code_out, .ch2_code_out);
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %0h got %0h", n, e, s);
        end
    endtask
    task conclude;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Codes are checked one edge after release, before any step can land
    task boot(input logic [1:0] v1, input logic [1:0] v2, input logic m);
        @(negedge clk_sys_in) resetn_in = 0;
        host.hold(1, v1);
        host.hold(2, v2);
        repeat (15) @(negedge clk_sys_in);
        resetn_in = 1;
        @(negedge clk_sys_in);
        chk("mode", {m, m}, {button_mode_out, bias_enable_out});
        chk("codes", 16'h2020, {ch1_code_out, 2'h0, ch2_code_out});
        $display("boot done");
    endtask
    task t_pulse;
        host.hold(1, 2'h0);
        host.pulse(1, 32);
        chk("wrap1", 16'h00, ch1_code_out);
        chk("idle2", 16'h20, ch2_code_out);
        host.pulse(2, 63);
        chk("down2", 16'h1F, ch2_code_out);
        $display("pulse done");
    endtask
    task t_duty;
        logic [15:0] hi;
        logic [15:0] hi2;
        logic [15:0] rise;
        logic prev;
        host.pulse(1, 8);
        repeat (4) @(posedge clk_sys_in);
        hi = 0;
        hi2 = 0;
        rise = 0;
        @(negedge clk_sys_in);
        prev = ch1_duty_out;
        // One full period of samples holds exactly one rising edge
        repeat (10240)
        begin
            @(negedge clk_sys_in);
            hi = hi + ch1_duty_out;
            hi2 = hi2 + ch2_duty_out;
            rise = rise + (ch1_duty_out && !prev);
            prev = ch1_duty_out;
        end
        chk("high", 16'h0500, hi);
        chk("high2", 16'h1360, hi2);
        chk("rises", 16'h0001, rise);
        $display("duty done");
    endtask
    task t_sleep;
        @(negedge clk_sys_in) sleep_request_n_in = 0;
        host.pulse(1, 3);
        chk("oe", 16'h0, {ch1_duty_oe_out, ch2_duty_oe_out, ch1_duty_out, ch2_duty_out});
        chk("held", 16'h08, ch1_code_out);
        @(negedge clk_sys_in) sleep_request_n_in = 1;
        repeat (4) @(negedge clk_sys_in);
        chk("back", 16'h0308, {ch1_duty_oe_out, ch2_duty_oe_out, 2'h0, ch1_code_out});
        $display("sleep done");
    endtask
    task t_button;
        repeat (4)
        begin
            host.press(1, 2'h1, 8);
            host.press(1, 2'h0, 8);
        end
        chk("bounce", 16'h20, ch1_code_out);
        host.press(1, 2'h1, 35);
        chk("one", 16'h21, ch1_code_out);
        host.press(1, 2'h0, 145);
        chk("repeat", 16'h1D, ch1_code_out);
        host.press(1, 2'h1, 2000);
        chk("top", 16'h3F, ch1_code_out);
        host.press(1, 2'h0, 2500);
        chk("floor", 16'h00, ch1_code_out);
        chk("ch2", 16'h20, ch2_code_out);
        $display("button done");
    endtask
    initial
    begin
        boot(2'h2, 2'h1, 1'b0);
        boot(2'h0, 2'h2, 1'b0);
        boot(2'h2, 2'h2, 1'b1);
        boot(2'h1, 2'h0, 1'b0);
        t_pulse;
        t_duty;
        t_sleep;
        boot(2'h2, 2'h2, 1'b1);
        t_button;
        conclude;
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys_in);
        fail_count++;
        conclude;
    end
endmodule
bind dpwm_top dpwm_checker chk_i (.clk_sys_in, .resetn_in, .ch1_step_input_in,
    .sleep_request_n_in, .ch1_duty_out, .ch1_duty_oe_out, .ch2_duty_oe_out,
    .bias_enable_out, .button_mode_out, .ch1_code_out, .ch2_code_out);
